// file: core/cache_cfg_pkg.sv
// Purpose: constants and types of the cache and shadow config bank
// Assumes: registers are 8 bits wide, one per aligned Avalon word
// Notes: byte address is four times the register index
// ==========================================================
package cache_cfg_pkg;

  // ==========================================================
  // Addressing
  localparam int IDX_W = 8;
  localparam int ADDR_W = IDX_W + 2;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [IDX_W-1:0] IDX_SHADOW = 8'h14;
  localparam logic [IDX_W-1:0] IDX_CHECK = 8'h15;
  localparam logic [IDX_W-1:0] IDX_CACHE1 = 8'h16;
  localparam logic [IDX_W-1:0] IDX_CACHE2 = 8'h17;
  localparam logic [IDX_W-1:0] IDX_RSVD = 8'h18;

  // ==========================================================
  // Reset values
  localparam logic [REG_W-1:0] RST_SHADOW = 8'h00;
  localparam logic [REG_W-1:0] RST_CHECK = 8'h20;
  localparam logic [REG_W-1:0] RST_CACHE1 = 8'h30;
  localparam logic [REG_W-1:0] RST_CACHE2 = 8'h00;
  localparam logic [REG_W-1:0] RD_ZERO = 8'h00;

  // ==========================================================
  // Field positions
  localparam int SH_READ = 4;
  localparam int SH_WRITE = 5;
  localparam int CK_LINEAR = 0;
  localparam int CK_CPU_LSB = 4;
  localparam int CK_MST_LSB = 6;
  localparam int C1_L1_EN = 0;
  localparam int C1_L2_EN = 1;
  localparam int C1_L1_WB = 2;
  localparam int C1_TAG8 = 3;
  localparam int C1_WR_NORM = 4;
  localparam int C1_RD_NORM = 5;
  localparam int C1_DATA_EARLY = 6;
  localparam int C1_TAG_EARLY = 7;
  localparam int C2_ORG_LSB = 0;
  localparam int C2_TWO_BANK = 2;
  localparam int C2_FMISS = 3;
  localparam int C2_FNDIRTY = 4;
  localparam int C2_FHIT = 5;
  localparam int C2_SH_L2 = 6;
  localparam int C2_SH_L1 = 7;
  localparam int BE_LANE = 0;

  // ==========================================================
  // Cycle decode
  localparam int CYC_ADDR_W = 24;
  localparam int REGION_LSB = 15;
  localparam int UPPER_LSB = 17;
  localparam logic [6:0] UPPER_TAG = 7'h07;
  localparam logic [1:0] TS_T1 = 2'h0;
  localparam logic [1:0] TS_T2 = 2'h1;
  localparam logic [1:0] TS_T3 = 2'h2;
  localparam logic [1:0] TS_RSVD = 2'h3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } bus_st_t;

  typedef struct packed {
    logic linear_burst;
    logic [1:0] cpu_point;
    logic [1:0] master_point;
    logic l1_enable;
    logic l2_enable;
    logic l1_policy_select;
    logic eight_bit_tag_force_dirty;
    logic l2_write_normal;
    logic l2_read_normal;
    logic data_we_early;
    logic tag_we_early;
    logic [1:0] sram_org;
    logic two_bank;
    logic force_miss;
    logic force_non_dirty;
    logic force_hit;
  } cfg_t;

  typedef struct packed {
    logic shadow_local;
    logic to_bus;
    logic l2_cacheable;
    logic l2_write_protect;
    logic l1_cacheable;
    logic decode_strobe;
    logic l2_hit;
    logic l2_dirty;
  } cycle_out_t;

  typedef struct packed {
    bus_st_t bus;
    logic waitreq;
    logic [REG_W-1:0] rdata;
    logic [REG_W-1:0] shadow;
    logic [REG_W-1:0] check;
    logic [REG_W-1:0] cache1;
    logic [REG_W-1:0] cache2;
    cycle_out_t cyc;
  } st_t;

endpackage : cache_cfg_pkg

// file: core/cache_shadow_cycle_config_regs.sv
// Purpose: config bank for shadow routing, check points and cache modes
// Assumes: Avalon-MM slave, one wait state, cycle inputs synchronous
// Notes: cycle outputs are registered, one clock after their inputs
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module cache_shadow_cycle_config_regs
  import cache_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  // Memory cycle under decode
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic cyc_code,
  input wire logic cyc_master,
  input wire logic [CYC_ADDR_W-1:0] cyc_addr,
  input wire logic cyc_tstate_end,
  input wire logic [1:0] cyc_tstate,
  input wire logic tag_match,
  input wire logic line_dirty,
  // Configuration and cycle results
  output cfg_t cfg,
  output cycle_out_t cyc_out
);

  // ==========================================================
  // Helpers

  // Reserved point code is taken as T3, the slowest and safest
  function automatic logic point_match(
    input logic [1:0] sel,
    input logic [1:0] ts
  );
    logic [1:0] eff;
    eff = (sel == TS_RSVD) ? TS_T3 : sel;
    point_match = (eff == ts);
  endfunction : point_match

  function automatic logic [REG_W-1:0] reg_read(
    input logic [IDX_W-1:0] idx,
    input st_t s
  );
    case (idx)
      IDX_SHADOW: reg_read = s.shadow;
      IDX_CHECK: reg_read = s.check;
      IDX_CACHE1: reg_read = s.cache1;
      IDX_CACHE2: reg_read = s.cache2;
      default: reg_read = RD_ZERO;
    endcase
  endfunction : reg_read

  // ==========================================================
  // State

  st_t st;
  st_t next_st;
  logic [IDX_W-1:0] reg_idx;
  logic lane_ok;
  logic in_upper;
  logic [1:0] region;
  logic region_on;
  logic route_local;
  logic [1:0] point_sel;
  logic l2_raw_hit;

  assign reg_idx = address[ADDR_W-1:2];
  assign lane_ok = byteenable[BE_LANE];
  assign in_upper = (cyc_addr[CYC_ADDR_W-1:UPPER_LSB] == UPPER_TAG);
  assign region = cyc_addr[UPPER_LSB-1:REGION_LSB];

  // ==========================================================
  // Next state

  always_comb begin
    next_st = st;
    next_st.waitreq = 1'b1;

    // Bus: request seen in idle, answered next cycle
    case (st.bus)
      BUS_IDLE: begin
        if (read || write) begin
          next_st.bus = BUS_ACK;
          next_st.waitreq = 1'b0;
          next_st.rdata = reg_read(reg_idx, st);
        end
      end
      BUS_ACK: begin
        next_st.bus = BUS_IDLE;
        // Write lands on the edge that sees waitrequest low
        if (write && lane_ok) begin
          case (reg_idx)
            IDX_SHADOW: next_st.shadow = writedata[REG_W-1:0];
            IDX_CHECK: next_st.check = writedata[REG_W-1:0];
            IDX_CACHE1: next_st.cache1 = writedata[REG_W-1:0];
            IDX_CACHE2: next_st.cache2 = writedata[REG_W-1:0];
            default: next_st.rdata = st.rdata;
          endcase
        end
      end
      default: begin
        next_st.bus = BUS_IDLE;
      end
    endcase

    // Shadow routing
    region_on = st.shadow[region];
    if (cyc_write) begin
      route_local = st.shadow[SH_WRITE];
    end else begin
      route_local = st.shadow[SH_READ];
    end
    next_st.cyc.shadow_local = cyc_valid && in_upper && region_on && route_local;
    next_st.cyc.to_bus = cyc_valid && in_upper && !(region_on && route_local);

    // Shadow cacheability
    next_st.cyc.l2_cacheable = next_st.cyc.shadow_local && st.cache2[C2_SH_L2];
    next_st.cyc.l2_write_protect = next_st.cyc.l2_cacheable && cyc_write;
    next_st.cyc.l1_cacheable = next_st.cyc.shadow_local && !cyc_code && st.cache2[C2_SH_L1];

    // Check point strobe for decode and tag compare
    if (cyc_master) begin
      point_sel = st.check[CK_MST_LSB +: 2];
    end else begin
      point_sel = st.check[CK_CPU_LSB +: 2];
    end
    next_st.cyc.decode_strobe = cyc_valid && cyc_tstate_end && point_match(point_sel, cyc_tstate);

    // L2 lookup; forced miss wins over forced hit
    l2_raw_hit = tag_match;
    if (st.cache2[C2_FMISS]) begin
      l2_raw_hit = 1'b0;
    end else if (st.cache2[C2_FHIT]) begin
      l2_raw_hit = 1'b1;
    end
    next_st.cyc.l2_hit = st.cache1[C1_L2_EN] && l2_raw_hit;

    // Dirty; diagnostic non-dirty wins over tag-8 forcing
    if (st.cache2[C2_FNDIRTY]) begin
      next_st.cyc.l2_dirty = 1'b0;
    end else if (st.cache1[C1_TAG8]) begin
      next_st.cyc.l2_dirty = 1'b1;
    end else begin
      next_st.cyc.l2_dirty = line_dirty;
    end
  end

  // ==========================================================
  // Registers

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st.bus <= BUS_IDLE;
      st.waitreq <= 1'b1;
      st.rdata <= RD_ZERO;
      st.shadow <= RST_SHADOW;
      st.check <= RST_CHECK;
      st.cache1 <= RST_CACHE1;
      st.cache2 <= RST_CACHE2;
      st.cyc <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs

  assign readdata = {{(DATA_W-REG_W){1'b0}}, st.rdata};
  assign waitrequest = st.waitreq;
  assign cyc_out = st.cyc;

  assign cfg.linear_burst = st.check[CK_LINEAR];
  assign cfg.cpu_point = st.check[CK_CPU_LSB +: 2];
  assign cfg.master_point = st.check[CK_MST_LSB +: 2];
  assign cfg.l1_enable = st.cache1[C1_L1_EN];
  assign cfg.l2_enable = st.cache1[C1_L2_EN];
  assign cfg.l1_policy_select = st.cache1[C1_L1_WB];
  assign cfg.eight_bit_tag_force_dirty = st.cache1[C1_TAG8];
  assign cfg.l2_write_normal = st.cache1[C1_WR_NORM];
  assign cfg.l2_read_normal = st.cache1[C1_RD_NORM];
  assign cfg.data_we_early = st.cache1[C1_DATA_EARLY];
  assign cfg.tag_we_early = st.cache1[C1_TAG_EARLY];
  assign cfg.sram_org = st.cache2[C2_ORG_LSB +: 2];
  assign cfg.two_bank = st.cache2[C2_TWO_BANK];
  assign cfg.force_miss = st.cache2[C2_FMISS];
  assign cfg.force_non_dirty = st.cache2[C2_FNDIRTY];
  assign cfg.force_hit = st.cache2[C2_FHIT];

  // ==========================================================
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  logic wd_bit_l1;
  logic wd_bit_two_bank;
  assign wd_bit_l1 = writedata[C1_L1_EN];
  assign wd_bit_two_bank = writedata[C2_TWO_BANK];

  sequence seq_req_idle;
    (read || write) && st.bus == BUS_IDLE;
  endsequence

  sequence seq_ack_release;
    !waitrequest ##1 waitrequest;
  endsequence

  property p_one_wait;
    seq_req_idle |-> waitrequest ##1 seq_ack_release;
  endproperty

  chk_bus_one_wait: assert property (p_one_wait)
    else $error("answer not one cycle after request");

  chk_rsvd_reads_zero: assert property (
    seq_req_idle ##0 (read && reg_idx == IDX_RSVD) |=> !waitrequest && readdata == '0)
    else $error("reserved index did not read zero");

  chk_l1_write_lands: assert property (
    (st.bus == BUS_ACK && write && lane_ok && reg_idx == IDX_CACHE1)
      |=> cfg.l1_enable == $past(wd_bit_l1))
    else $error("L1 enable did not take written value");

  chk_bank_write_held: assert property (
    (st.bus == BUS_ACK && write && lane_ok && reg_idx == IDX_CACHE2)
      |=> (cfg.two_bank == $past(wd_bit_two_bank)) [*2])
    else $error("bank select not stored");

  chk_shadow_read_local: assert property (
    (cyc_valid && !cyc_write && in_upper && st.shadow[region] && st.shadow[SH_READ]
      && $stable(st.shadow)) |=> cyc_out.shadow_local && !cyc_out.to_bus)
    else $error("shadow read not routed locally");

  chk_write_to_bus: assert property (
    (cyc_valid && cyc_write && in_upper && !st.shadow[SH_WRITE] && $stable(st.shadow))
      |=> cyc_out.to_bus && !cyc_out.shadow_local)
    else $error("unshadowed write not sent to bus");

  chk_force_miss: assert property (
    (cfg.force_miss && $stable(st.cache2)) |=> !cyc_out.l2_hit)
    else $error("forced miss reported hit");

  chk_non_dirty: assert property (
    (cfg.force_non_dirty && $stable(st.cache2)) |=> !cyc_out.l2_dirty)
    else $error("forced non-dirty reported dirty");

  chk_write_protect: assert property (
    cyc_out.l2_write_protect |-> cyc_out.l2_cacheable && $past(cyc_write) && cyc_out.shadow_local)
    else $error("write protect without cacheable shadow write");

  chk_cpu_point: assert property (
    (cyc_valid && cyc_tstate_end && !cyc_master && cfg.cpu_point == TS_T1 && cyc_tstate == TS_T2)
      |=> !cyc_out.decode_strobe)
    else $error("decode strobe at wrong processor point");

  chk_master_point: assert property (
    (cyc_valid && cyc_tstate_end && cyc_master && cfg.master_point == cyc_tstate
      && cfg.master_point != TS_RSVD) |=> cyc_out.decode_strobe)
    else $error("missing master decode strobe");

  sequence seq_ack_write;
    st.bus == BUS_ACK && write && lane_ok;
  endsequence

  chk_ack_after_req: assert property (
    !waitrequest |-> $past(read || write) && $past(st.bus) == BUS_IDLE)
    else $error("answer without a request");

  chk_wait_when_idle: assert property (
    (st.bus == BUS_IDLE && !read && !write) |=> waitrequest)
    else $error("waitrequest low with no request");

  chk_rdata_held: assert property (
    !((read || write) && st.bus == BUS_IDLE) |=> $stable(readdata))
    else $error("read data moved without a request");

  chk_rsvd_write_ignored: assert property (
    seq_ack_write ##0 (reg_idx == IDX_RSVD)
      |=> $stable(st.shadow) && $stable(st.check) && $stable(st.cache1) && $stable(st.cache2))
    else $error("reserved write changed a register");

  chk_lane_off_ignored: assert property (
    (st.bus == BUS_ACK && write && !lane_ok)
      |=> $stable(st.shadow) && $stable(st.check) && $stable(st.cache1) && $stable(st.cache2))
    else $error("write with lane zero off changed a register");

  chk_cfg_held: assert property (
    !(st.bus == BUS_ACK && write) |=> $stable(cfg))
    else $error("configuration moved without a write");

  chk_shadow_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_SHADOW) |=> st.shadow == $past(writedata[REG_W-1:0]))
    else $error("shadow control not stored");

  chk_linear_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CHECK) |=> cfg.linear_burst == $past(writedata[CK_LINEAR]))
    else $error("linear burst bit not stored");

  chk_cpu_point_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CHECK) |=> cfg.cpu_point == $past(writedata[CK_CPU_LSB +: 2]))
    else $error("processor point not stored");

  chk_master_point_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CHECK) |=> cfg.master_point == $past(writedata[CK_MST_LSB +: 2]))
    else $error("master point not stored");

  chk_l2_enable_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CACHE1) |=> cfg.l2_enable == $past(writedata[C1_L2_EN]))
    else $error("L2 enable not stored");

  chk_policy_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CACHE1) |=> cfg.l1_policy_select == $past(writedata[C1_L1_WB]))
    else $error("L1 policy not stored");

  chk_tag_mode_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CACHE1) |=> cfg.eight_bit_tag_force_dirty == $past(writedata[C1_TAG8]))
    else $error("tag mode not stored");

  chk_wr_timing_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CACHE1) |=> cfg.l2_write_normal == $past(writedata[C1_WR_NORM]))
    else $error("L2 write timing not stored");

  chk_rd_timing_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CACHE1) |=> cfg.l2_read_normal == $past(writedata[C1_RD_NORM]))
    else $error("L2 read timing not stored");

  chk_early_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CACHE1) |=> cfg.tag_we_early == $past(writedata[C1_TAG_EARLY]))
    else $error("tag strobe timing not stored");

  chk_org_lands: assert property (
    seq_ack_write ##0 (reg_idx == IDX_CACHE2) |=> cfg.sram_org == $past(writedata[C2_ORG_LSB +: 2]))
    else $error("SRAM organisation not stored");

  chk_force_hit: assert property (
    (cfg.force_hit && !cfg.force_miss && cfg.l2_enable)
      |=> cyc_out.l2_hit)
    else $error("forced hit reported miss");

  chk_l2_off_miss: assert property (
    !cfg.l2_enable |=> !cyc_out.l2_hit)
    else $error("hit reported with L2 disabled");

  chk_tag8_dirty: assert property (
    (cfg.eight_bit_tag_force_dirty && !cfg.force_non_dirty)
      |=> cyc_out.l2_dirty)
    else $error("eight bit tag mode reported clean");

  chk_invalid_quiet: assert property (
    !cyc_valid |=> !cyc_out.shadow_local && !cyc_out.to_bus && !cyc_out.l2_cacheable
      && !cyc_out.decode_strobe)
    else $error("result raised with no cycle");

  chk_region_off_bus: assert property (
    (cyc_valid && in_upper && !st.shadow[region]) |=> cyc_out.to_bus && !cyc_out.shadow_local)
    else $error("disabled region not sent to bus");

  chk_write_local: assert property (
    (cyc_valid && cyc_write && in_upper && st.shadow[region] && st.shadow[SH_WRITE])
      |=> cyc_out.shadow_local && !cyc_out.to_bus)
    else $error("shadow write not routed locally");

  chk_read_to_bus: assert property (
    (cyc_valid && !cyc_write && in_upper && !st.shadow[SH_READ]) |=> cyc_out.to_bus)
    else $error("unshadowed read not sent to bus");

  chk_no_shadow_l2: assert property (
    !st.cache2[C2_SH_L2] |=> !cyc_out.l2_cacheable)
    else $error("shadow cacheable in L2 while disabled");

  chk_l1_source: assert property (
    cyc_out.l1_cacheable |-> cyc_out.shadow_local && $past(st.cache2[C2_SH_L1]) && !$past(cyc_code))
    else $error("L1 cacheable without enabled shadow data");

  chk_strobe_source: assert property (
    cyc_out.decode_strobe |-> $past(cyc_valid) && $past(cyc_tstate_end))
    else $error("decode strobe without a T-state end");

  chk_rsvd_point_t3: assert property (
    (cyc_valid && cyc_tstate_end && !cyc_master && cfg.cpu_point == TS_RSVD && cyc_tstate == TS_T3)
      |=> cyc_out.decode_strobe)
    else $error("reserved processor point not taken as T3");

endmodule : cache_shadow_cycle_config_regs

// file: sim/tb_cache_shadow_cycle_config_regs.sv
// Purpose: self-checking bench for the cache and shadow config bank
// Assumes: Avalon access answered after one wait state, cycle results one clock late
// Notes: expectations come from the register map, never from the outputs
`timescale 1ns/1ps
module tb_cache_shadow_cycle_config_regs
  import cache_cfg_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0] byteenable = 4'h1;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic cyc_valid = 1'b0, cyc_write = 1'b0, cyc_code = 1'b0, cyc_master = 1'b0;
  logic [CYC_ADDR_W-1:0] cyc_addr = '0;
  logic cyc_tstate_end = 1'b0, tag_match = 1'b0, line_dirty = 1'b0;
  logic [1:0] cyc_tstate = 2'h0;
  cfg_t cfg;
  cycle_out_t cyc_out;
  int errors = 0;
  int check_count = 0;
  logic [DATA_W-1:0] rv;
  logic [7:0] pk[4] = '{8'h01, 8'h50, 8'ha0, 8'hf1};
  logic [7:0] p1[4] = '{8'h5a, 8'ha5, 8'hff, 8'h00};
  logic [7:0] p2[4] = '{8'h55, 8'haa, 8'h03, 8'hfc};

  always #4 clk_sys = ~clk_sys;

  cache_shadow_cycle_config_regs dut_u (
    .clk_sys, .nrst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .cyc_valid, .cyc_write, .cyc_code, .cyc_master, .cyc_addr, .cyc_tstate_end, .cyc_tstate,
    .tag_match, .line_dirty, .cfg, .cyc_out
  );

  // ==========================================================
  // Shared helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Request held until waitrequest is sampled low; the bound only guards a hang
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic be);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, d};
    byteenable <= {3'h0, be};
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rv = readdata;
    chk("bus answer", waitrequest, 32'h0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 1'b1);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 1'b1);
    chk($sformatf("register %h", idx), rv, {24'h0, exp});
  endtask : rdc

  task automatic cy(input logic v, w, c, m, input logic [23:0] a, input logic te,
                    input logic [1:0] ts, input logic tm, ld);
    @(posedge clk_sys);
    cyc_valid <= v;
    cyc_write <= w;
    cyc_code <= c;
    cyc_master <= m;
    cyc_addr <= a;
    cyc_tstate_end <= te;
    cyc_tstate <= ts;
    tag_match <= tm;
    line_dirty <= ld;
    @(posedge clk_sys);
    #1;
  endtask : cy

  function automatic logic [7:0] ckf();
    return {cfg.master_point, cfg.cpu_point, 3'h0, cfg.linear_burst};
  endfunction : ckf

  function automatic logic [7:0] c1f();
    return {cfg.tag_we_early, cfg.data_we_early, cfg.l2_read_normal, cfg.l2_write_normal,
            cfg.eight_bit_tag_force_dirty, cfg.l1_policy_select, cfg.l2_enable, cfg.l1_enable};
  endfunction : c1f

  function automatic logic [7:0] c2f();
    return {2'h0, cfg.force_hit, cfg.force_non_dirty, cfg.force_miss, cfg.two_bank, cfg.sram_org};
  endfunction : c2f

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdc(IDX_SHADOW, 8'h00);
    rdc(IDX_CHECK, 8'h20);
    rdc(IDX_CACHE1, 8'h30);
    rdc(IDX_CACHE2, 8'h00);
    rdc(IDX_RSVD, 8'h00);
    chk("check fields", ckf(), 8'h20);
    chk("cache one fields", c1f(), 8'h30);
    chk("cache two fields", c2f(), 8'h00);
    $display("done reset defaults");
  endtask : t_reset

  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CHECK, pk[i]);
      wr(IDX_CACHE1, p1[i]);
      wr(IDX_CACHE2, p2[i]);
      rdc(IDX_CHECK, pk[i]);
      rdc(IDX_CACHE1, p1[i]);
      rdc(IDX_CACHE2, p2[i]);
      chk("check fields", ckf(), pk[i] & 8'hf1);
      chk("cache one fields", c1f(), p1[i]);
      chk("cache two fields", c2f(), {2'h0, p2[i][5:0]});
    end
    // Lane zero disabled: the write must not land
    bus(1'b1, IDX_CACHE1, 8'h77, 1'b0);
    rdc(IDX_CACHE1, 8'h00);
    wr(IDX_RSVD, 8'hff);
    rdc(IDX_RSVD, 8'h00);
    rdc(8'h40, 8'h00);
    $display("done register access");
  endtask : t_regs

  task automatic t_shadow();
    wr(IDX_SHADOW, 8'h98);
    rdc(IDX_SHADOW, 8'h98);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h0f8000, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("local read", {cyc_out.shadow_local, cyc_out.to_bus}, 2'b10);
    cy(1'b1, 1'b1, 1'b0, 1'b0, 24'h0fffff, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("bus write", {cyc_out.shadow_local, cyc_out.to_bus}, 2'b01);
    wr(IDX_SHADOW, 8'hb9);
    cy(1'b1, 1'b1, 1'b0, 1'b0, 24'h0e0000, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("local write", {cyc_out.shadow_local, cyc_out.to_bus}, 2'b10);
    cy(1'b1, 1'b1, 1'b0, 1'b0, 24'h0e8000, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("region off", {cyc_out.shadow_local, cyc_out.to_bus}, 2'b01);
    wr(IDX_SHADOW, 8'ha9);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h0e7fff, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("read off", {cyc_out.shadow_local, cyc_out.to_bus}, 2'b01);
    cy(1'b0, 1'b0, 1'b0, 1'b0, 24'h0e0000, 1'b1, 2'h0, 1'b0, 1'b0);
    chk("no cycle", {cyc_out.shadow_local, cyc_out.to_bus, cyc_out.decode_strobe}, 3'b000);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("below upper", {cyc_out.shadow_local, cyc_out.to_bus}, 2'b00);
    $display("done shadow routing");
  endtask : t_shadow

  task automatic t_cache();
    wr(IDX_SHADOW, 8'hb9);
    wr(IDX_CACHE1, 8'h32);
    wr(IDX_CACHE2, 8'hc0);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h0f8000, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("data read", {cyc_out.l2_cacheable, cyc_out.l2_write_protect, cyc_out.l1_cacheable}, 3'b101);
    cy(1'b1, 1'b1, 1'b0, 1'b0, 24'h0f8000, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("data write", {cyc_out.l2_cacheable, cyc_out.l2_write_protect}, 2'b11);
    cy(1'b1, 1'b0, 1'b1, 1'b0, 24'h0f8000, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("code read", {cyc_out.l2_cacheable, cyc_out.l1_cacheable}, 2'b10);
    wr(IDX_CACHE2, 8'h00);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h0f8000, 1'b0, 2'h0, 1'b1, 1'b1);
    chk("no cacheable", {cyc_out.l2_cacheable, cyc_out.l1_cacheable}, 2'b00);
    chk("plain hit dirty", {cyc_out.l2_hit, cyc_out.l2_dirty}, 2'b11);
    wr(IDX_CACHE2, 8'h08);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b0, 2'h0, 1'b1, 1'b0);
    chk("forced miss", cyc_out.l2_hit, 1'b0);
    wr(IDX_CACHE2, 8'h20);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("forced hit", cyc_out.l2_hit, 1'b1);
    wr(IDX_CACHE2, 8'h10);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b0, 2'h0, 1'b1, 1'b1);
    chk("non dirty", cyc_out.l2_dirty, 1'b0);
    wr(IDX_CACHE2, 8'h00);
    wr(IDX_CACHE1, 8'h3a);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b0, 2'h0, 1'b1, 1'b0);
    chk("forced dirty", cyc_out.l2_dirty, 1'b1);
    $display("done cache modes");
  endtask : t_cache

  task automatic t_strobe();
    wr(IDX_CHECK, 8'h00);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b1, 2'h0, 1'b0, 1'b0);
    chk("cpu at T1", cyc_out.decode_strobe, 1'b1);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b1, 2'h1, 1'b0, 1'b0);
    chk("cpu not T2", cyc_out.decode_strobe, 1'b0);
    wr(IDX_CHECK, 8'h90);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b1, 2'h1, 1'b0, 1'b0);
    chk("cpu at T2", cyc_out.decode_strobe, 1'b1);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b0, 2'h1, 1'b0, 1'b0);
    chk("no end pulse", cyc_out.decode_strobe, 1'b0);
    cy(1'b1, 1'b0, 1'b0, 1'b1, 24'h001000, 1'b1, 2'h2, 1'b0, 1'b0);
    chk("master at T3", cyc_out.decode_strobe, 1'b1);
    cy(1'b1, 1'b0, 1'b0, 1'b1, 24'h001000, 1'b1, 2'h1, 1'b0, 1'b0);
    chk("master not T2", cyc_out.decode_strobe, 1'b0);
    wr(IDX_CHECK, 8'h30);
    cy(1'b1, 1'b0, 1'b0, 1'b0, 24'h001000, 1'b1, 2'h2, 1'b0, 1'b0);
    chk("cpu reserved as T3", cyc_out.decode_strobe, 1'b1);
    $display("done check points");
  endtask : t_strobe

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk_sys);
    chk("waitrequest in reset", waitrequest, 32'h1);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_shadow();
    t_cache();
    t_strobe();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #40000;
    errors++;
    end_of_test();
  end
endmodule : tb_cache_shadow_cycle_config_regs
